// ===== core/i2c_link_pkg.sv
package i2c_link_pkg;

	// Bus address and direction codes
	localparam logic [6:0] SLAVE_ADDR = 7'h30;
	localparam logic [7:0] ADDR_WRITE = 8'h60;
	localparam logic [7:0] ADDR_READ = 8'h61;
	localparam int DIR_BIT = 0;

	// Byte shape
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] ACK_SLOT = 4'h8;

	// Clock rates and divider derivation
	localparam int CLK_HZ = 125000000;
	localparam int STD_HZ = 100000;
	localparam int FAST_HZ = 400000;
	localparam int QUARTER_FAST = CLK_HZ / (FAST_HZ * 4);

	// Register pointer reset value
	localparam logic [7:0] PTR_RESET = 8'h00;

endpackage : i2c_link_pkg

// ===== core/i2c_link_if.sv
`timescale 1ns/1ns
interface i2c_link_if;
	logic scl_o;
	logic scl_oe_n;
	logic sda_m_o;
	logic sda_m_oe_n;
	logic sda_s_o;
	logic sda_s_oe_n;
	logic scl;
	logic sda;

	// Open-drain wired AND: SDA of both ends, SCL driven by the master alone
	assign scl = scl_oe_n ? 1'b1 : scl_o;
	assign sda = (sda_m_oe_n ? 1'b1 : sda_m_o) & (sda_s_oe_n ? 1'b1 : sda_s_o);

	modport master (
		output scl_o, scl_oe_n, sda_m_o, sda_m_oe_n,
		input scl, sda
	);

	modport slave (
		output sda_s_o, sda_s_oe_n,
		input scl, sda
	);
endinterface : i2c_link_if

// ===== core/line_sync.sv
`timescale 1ns/1ns
module line_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Raw lines
	input wire logic scl_in,
	input wire logic sda_in,
	// Synchronised levels and conditions
	output logic scl_s,
	output logic sda_s,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_det,
	output logic stop_det
);
	typedef struct packed {
		logic [1:0] scl_meta;
		logic [1:0] sda_meta;
		logic scl_prev;
		logic sda_prev;
	} sync_t;

	sync_t q, d;

	always_comb begin
		d = q;
		d.scl_meta = {q.scl_meta[0], scl_in};
		d.sda_meta = {q.sda_meta[0], sda_in};
		d.scl_prev = q.scl_meta[1];
		d.sda_prev = q.sda_meta[1];
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '{scl_meta: 2'h3, sda_meta: 2'h3, scl_prev: 1'b1, sda_prev: 1'b1};
		end else begin
			q <= d;
		end
	end

	assign scl_s = q.scl_meta[1];
	assign sda_s = q.sda_meta[1];
	assign scl_rise = q.scl_meta[1] & ~q.scl_prev;
	assign scl_fall = ~q.scl_meta[1] & q.scl_prev;
	assign start_det = q.scl_meta[1] & q.scl_prev & q.sda_prev & ~q.sda_meta[1];
	assign stop_det = q.scl_meta[1] & q.scl_prev & ~q.sda_prev & q.sda_meta[1];
endmodule : line_sync

// ===== core/i2c_reg_slave.sv
`timescale 1ns/1ns
module i2c_reg_slave #(
	parameter logic [6:0] ADDR = i2c_link_pkg::SLAVE_ADDR
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Bus
	i2c_link_if.slave bus,
	// Register bank port
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data,
	// Status
	output logic busy
);
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_ADDR = 6'b000010,
		ST_PTR = 6'b000100,
		ST_WDATA = 6'b001000,
		ST_RDATA = 6'b010000,
		ST_IGNORE = 6'b100000
	} state_t;

	typedef struct packed {
		state_t st;
		logic [7:0] shift;
		logic [3:0] bitn;
		logic [7:0] ptr;
		logic ack_phase;
		logic master_nack;
		logic sda_low;
		logic wr_en;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
		logic busy;
	} slv_t;

	slv_t q, d;
	logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;

	line_sync u_sync (
		.clk(clk),
		.srst(srst),
		.scl_in(bus.scl),
		.sda_in(bus.sda),
		.scl_s(scl_s),
		.sda_s(sda_s),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_det(start_det),
		.stop_det(stop_det)
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.wr_en = 1'b0;
		if (start_det) begin
			d.st = ST_ADDR;
			d.bitn = 4'h0;
			d.ack_phase = 1'b0;
			d.sda_low = 1'b0;
		end else if (stop_det) begin
			d.st = ST_IDLE;
			d.sda_low = 1'b0;
		end else if (q.st != ST_IDLE && q.st != ST_IGNORE) begin
			if (scl_rise) begin
				if (!q.ack_phase) begin
					// Transmit shifter only moves on the falling clock
					if (q.st != ST_RDATA) begin
						d.shift = {q.shift[6:0], sda_s};
					end
					d.bitn = q.bitn + 4'h1;
				end else begin
					d.master_nack = sda_s;
				end
			end
			if (scl_fall) begin
				if (!q.ack_phase && q.bitn == i2c_link_pkg::ACK_SLOT) begin
					d.ack_phase = 1'b1;
					d.bitn = 4'h0;
					d.sda_low = 1'b0;
					unique case (q.st)
						ST_ADDR: begin
							if (q.shift[7:1] == ADDR) begin
								d.sda_low = 1'b1;
							end else begin
								d.st = ST_IGNORE;
								d.ack_phase = 1'b0;
							end
						end
						ST_PTR: begin
							d.ptr = q.shift;
							d.sda_low = 1'b1;
						end
						ST_WDATA: begin
							d.wr_en = 1'b1;
							d.wr_addr = q.ptr;
							d.wr_data = q.shift;
							d.ptr = q.ptr + 8'h01;
							d.sda_low = 1'b1;
						end
						ST_RDATA: begin
							d.ptr = q.ptr + 8'h01;
						end
						default: begin
						end
					endcase
				end else if (q.ack_phase) begin
					d.ack_phase = 1'b0;
					d.sda_low = 1'b0;
					unique case (q.st)
						ST_ADDR: begin
							if (q.shift[i2c_link_pkg::DIR_BIT]) begin
								d.st = ST_RDATA;
								d.sda_low = ~rd_data[7];
								d.shift = {rd_data[6:0], 1'b1};
								d.bitn = 4'h0;
							end else begin
								d.st = ST_PTR;
							end
						end
						ST_PTR: d.st = ST_WDATA;
						ST_RDATA: begin
							if (q.master_nack) begin
								d.st = ST_IGNORE;
							end else begin
								d.sda_low = ~rd_data[7];
								d.shift = {rd_data[6:0], 1'b1};
								d.bitn = 4'h0;
							end
						end
						default: begin
						end
					endcase
				end else if (q.st == ST_RDATA) begin
					d.sda_low = ~q.shift[7];
					d.shift = {q.shift[6:0], 1'b1};
				end
			end
		end
		d.busy = (d.st != ST_IDLE);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '{st: ST_IDLE, shift: 8'h00, bitn: 4'h0, ptr: i2c_link_pkg::PTR_RESET,
				ack_phase: 1'b0, master_nack: 1'b0, sda_low: 1'b0, wr_en: 1'b0,
				wr_addr: 8'h00, wr_data: 8'h00, busy: 1'b0};
		end else begin
			q <= d;
		end
	end

	// In read, bitn counts shifted-out bits the same way
	assign rd_addr = q.ptr;
	assign wr_en = q.wr_en;
	assign wr_addr = q.wr_addr;
	assign wr_data = q.wr_data;
	assign busy = q.busy;
	assign bus.sda_s_o = 1'b0;
	assign bus.sda_s_oe_n = ~q.sda_low;
endmodule : i2c_reg_slave

// ===== core/i2c_master_end.sv
`timescale 1ns/1ns
module i2c_master_end #(
	parameter int QUARTER = i2c_link_pkg::QUARTER_FAST
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Bus
	i2c_link_if.master bus,
	// Byte request
	input wire logic req_valid,
	input wire logic req_start,
	input wire logic req_stop,
	input wire logic req_read,
	input wire logic req_nack,
	input wire logic [7:0] req_data,
	output logic req_ready,
	// Byte answer
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_ack
);
	typedef enum logic [4:0] {
		M_IDLE = 5'b00001,
		M_START = 5'b00010,
		M_BIT = 5'b00100,
		M_STOP = 5'b01000,
		M_HOLD = 5'b10000
	} mstate_t;

	typedef struct packed {
		mstate_t st;
		logic [15:0] cnt;
		logic [1:0] ph;
		logic [3:0] bitn;
		logic [8:0] sh;
		logic [7:0] rx;
		logic rd;
		logic stop;
		logic scl_low;
		logic sda_low;
		logic rdy;
		logic vld;
		logic [7:0] data;
		logic ack;
		logic [1:0] s1;
	} mst_t;

	mst_t q, d;
	logic sda_in;
	logic tick;

	assign sda_in = q.s1[1];
	assign tick = (q.cnt == 16'(QUARTER - 1));

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.s1 = {q.s1[0], bus.sda};
		d.vld = 1'b0;
		d.cnt = tick ? 16'h0000 : q.cnt + 16'h0001;
		unique case (q.st)
			M_IDLE: begin
				if (req_valid && q.rdy) begin
					d.rdy = 1'b0;
					d.rd = req_read;
					d.stop = req_stop;
					d.sh = req_read ? {8'hFF, req_nack} : {req_data, 1'b1};
					d.bitn = 4'h0;
					d.ph = 2'h0;
					d.st = req_start ? M_START : M_BIT;
				end
			end
			M_START: if (tick) begin
				d.ph = q.ph + 2'h1;
				if (q.ph == 2'h0) begin
					d.sda_low = 1'b0;
					d.scl_low = 1'b0;
				end
				if (q.ph == 2'h1) d.sda_low = 1'b1;
				if (q.ph == 2'h2) begin
					d.scl_low = 1'b1;
					d.ph = 2'h0;
					d.st = M_BIT;
				end
			end
			M_BIT: if (tick) begin
				d.ph = q.ph + 2'h1;
				unique case (q.ph)
					2'h0: d.sda_low = ~q.sh[8];
					2'h1: d.scl_low = 1'b0;
					2'h2: begin
						// Acknowledge slot is not part of the data byte
						if (q.bitn != 4'h8) d.rx = {q.rx[6:0], sda_in};
						if (q.bitn == 4'h8) d.ack = ~sda_in;
					end
					default: begin
						d.scl_low = 1'b1;
						d.sh = {q.sh[7:0], 1'b1};
						d.bitn = q.bitn + 4'h1;
						if (q.bitn == 4'h8) begin
							d.vld = 1'b1;
							d.data = q.rx;
							d.st = q.stop ? M_STOP : M_HOLD;
						end
					end
				endcase
			end
			M_STOP: if (tick) begin
				d.ph = q.ph + 2'h1;
				if (q.ph == 2'h0) d.sda_low = 1'b1;
				if (q.ph == 2'h1) d.scl_low = 1'b0;
				if (q.ph == 2'h2) d.sda_low = 1'b0;
				if (q.ph == 2'h3) begin
					d.st = M_IDLE;
					d.rdy = 1'b1;
				end
			end
			M_HOLD: begin
				d.st = M_IDLE;
				d.rdy = 1'b1;
				d.ph = 2'h0;
			end
			default: d.st = M_IDLE;
		endcase
		// Receiver data bits: release SDA so the slave drives it
		if (q.st == M_BIT && tick && q.ph == 2'h0 && q.rd && q.bitn != 4'h8) d.sda_low = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '{st: M_IDLE, cnt: 16'h0000, ph: 2'h0, bitn: 4'h0, sh: 9'h1FF, rx: 8'h00,
				rd: 1'b0, stop: 1'b0, scl_low: 1'b0, sda_low: 1'b0, rdy: 1'b1, vld: 1'b0,
				data: 8'h00, ack: 1'b0, s1: 2'h3};
		end else begin
			q <= d;
		end
	end

	assign req_ready = q.rdy;
	assign rsp_valid = q.vld;
	assign rsp_data = q.data;
	assign rsp_ack = q.ack;
	assign bus.scl_o = 1'b0;
	assign bus.scl_oe_n = ~q.scl_low;
	assign bus.sda_m_o = 1'b0;
	assign bus.sda_m_oe_n = ~q.sda_low;
endmodule : i2c_master_end

// ===== sim/i2c_register_slave_checker.sv
`timescale 1ns/1ns
module i2c_register_slave_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Link lines
	input wire logic sda_s_oe_n,
	input wire logic scl,
	input wire logic sda
);
	logic scl_p, sda_p, first, wr, ign, nk;
	logic [3:0] bn, lo;
	logic [7:0] sh;
	wire rise = scl & ~scl_p;
	wire strt = scl & scl_p & sda_p & ~sda;
	wire nine = rise & (bn == 4'h8);
	always_ff @(posedge clk) begin
		scl_p <= scl;
		sda_p <= sda;
		lo <= scl ? 4'h0 : (lo == 4'hF ? lo : lo + 4'h1);
		if (srst | strt) begin
			bn <= 4'h0;
			first <= 1'b1;
			ign <= 1'b0;
			nk <= 1'b0;
		end else if (rise) begin
			sh <= {sh[6:0], sda};
			bn <= nine ? 4'h0 : bn + 4'h1;
			if (nine) begin
				first <= 1'b0;
			end
			if (nine & first) begin
				wr <= ~sh[0];
				ign <= sh[7:1] != i2c_link_pkg::SLAVE_ADDR;
			end
			if (nine & ~first & ~wr & sda) begin
				nk <= 1'b1;
			end
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_slave_hold_high: assert property (scl && scl_p |-> $stable(sda_s_oe_n))
		else $error("slave data moved with clock high");
	a_addr_ack_low: assert property (nine && first && sh[7:1] == i2c_link_pkg::SLAVE_ADDR
		|-> !sda_s_oe_n [*6])
		else $error("address not acknowledged");
	a_data_ack_low: assert property (nine && !first && wr && !ign |-> !sda_s_oe_n [*6])
		else $error("write byte not acknowledged");
	a_mismatch_released: assert property (ign |-> sda_s_oe_n)
		else $error("slave drove after foreign address");
	a_nack_released: assert property (nk |-> sda_s_oe_n)
		else $error("slave drove after final read byte");
	a_start_from_high: assert property (strt |-> $past(scl, 4) && $past(sda, 4))
		else $error("start without high lines");
	a_change_clock_low: assert property ($changed(sda_s_oe_n) |-> !scl && lo <= 4'h6)
		else $error("slave data change outside clock low");
	a_clock_high_span: assert property ($rose(scl) |-> scl [*7])
		else $error("clock high phase too short");
	cover property (nine && first && !sh[0]);
	cover property (nk);
	cover property (ign);
endmodule : i2c_register_slave_checker

// ===== sim/i2c_register_slave_tb_top.sv
`timescale 1ns/1ns
module i2c_register_slave_tb_top;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic rv = 1'b0, rs = 1'b0, rp = 1'b0, rr = 1'b0, rn = 1'b0;
	logic [7:0] dat = 8'h00;
	logic rdy, vld, ack, wen, busy;
	logic [7:0] rdat, wa, wd, ra, wsh;
	logic [7:0] bank [256];
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	always #4 clk = ~clk;
	i2c_link_if u_i2c_link_if ();
	i2c_master_end #(.QUARTER(8)) u_i2c_master_end (.clk(clk), .srst(srst),
		.bus(u_i2c_link_if), .req_valid(rv), .req_start(rs), .req_stop(rp),
		.req_read(rr), .req_nack(rn), .req_data(dat), .req_ready(rdy),
		.rsp_valid(vld), .rsp_data(rdat), .rsp_ack(ack));
	i2c_reg_slave u_i2c_reg_slave (.clk(clk), .srst(srst), .bus(u_i2c_link_if),
		.wr_en(wen), .wr_addr(wa), .wr_data(wd), .rd_addr(ra), .rd_data(bank[ra]),
		.busy(busy));
	i2c_register_slave_checker u_i2c_register_slave_checker (.clk(clk), .srst(srst),
		.sda_s_oe_n(u_i2c_link_if.sda_s_oe_n), .scl(u_i2c_link_if.scl),
		.sda(u_i2c_link_if.sda));
	always @(posedge clk) begin
		if (wen) bank[wa] <= wd;
	end
	// Bits as seen on the wire at each clock rise
	always @(posedge u_i2c_link_if.scl) wsh <= {wsh[6:0], u_i2c_link_if.sda};
	////////////////////////////////////////////////////////////////
	task summarize;
		$display("Checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : summarize
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			summarize();
		end
	end
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic xfer(input logic s, p, r, n, input logic [7:0] d,
		output logic [7:0] q, output logic a);
		@(negedge clk);
		while (rdy !== 1'b1) @(negedge clk);
		{rs, rp, rr, rn, dat} = {s, p, r, n, d};
		rv = 1'b1;
		@(negedge clk);
		rv = 1'b0;
		while (vld !== 1'b1) @(negedge clk);
		q = rdat;
		a = ack;
	endtask : xfer
	////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] q;
		logic a;
		for (int i = 0; i < 256; i++) bank[i] = ~8'(i);
		repeat (3) @(negedge clk);
		srst = 1'b0;
		xfer(1, 0, 0, 0, 8'h60, q, a);
		chk("addr ack", 8'h01, {7'h00, a});
		chk("wire bits", 8'hC0, wsh);
		xfer(0, 0, 0, 0, 8'h05, q, a);
		xfer(0, 0, 0, 0, 8'hA5, q, a);
		chk("data ack", 8'h01, {7'h00, a});
		xfer(0, 1, 0, 0, 8'h3C, q, a);
		while (rdy !== 1'b1) @(negedge clk);
		repeat (4) @(negedge clk);
		chk("reg5", 8'hA5, bank[5]);
		chk("reg6", 8'h3C, bank[6]);
		chk("idle lines", 8'h03, {6'h00, u_i2c_link_if.scl, u_i2c_link_if.sda});
		chk("busy", 8'h00, {7'h00, busy});
		xfer(1, 0, 0, 0, 8'h60, q, a);
		xfer(0, 0, 0, 0, 8'h05, q, a);
		xfer(1, 0, 0, 0, 8'h61, q, a);
		chk("read ack", 8'h01, {7'h00, a});
		xfer(0, 0, 1, 0, 8'hFF, q, a);
		chk("rd5", 8'hA5, q);
		xfer(0, 1, 1, 1, 8'hFF, q, a);
		chk("rd6", 8'h3C, q);
		chk("last nack", 8'h00, {7'h00, a});
		xfer(1, 0, 0, 0, 8'h61, q, a);
		xfer(0, 1, 1, 1, 8'hFF, q, a);
		chk("rd7", 8'hF8, q);
		xfer(1, 0, 0, 0, 8'h62, q, a);
		chk("foreign ack", 8'h00, {7'h00, a});
		xfer(0, 1, 0, 0, 8'h77, q, a);
		xfer(1, 0, 0, 0, 8'h61, q, a);
		xfer(0, 1, 1, 1, 8'hFF, q, a);
		chk("rd8", 8'hF7, q);
		summarize();
	end
endmodule : i2c_register_slave_tb_top
